/* File: verilog/serial3_pkg.sv */
// Purpose: Shared constants and types for the three-line converter port.
// Assumes: Both ends run on clk_sys at 100 MHz.
// Notes: Host-made shift clock timing is set here.
package serial3_pkg;

  // ----------------------------------------------------------------
  // Word sizes
  // ----------------------------------------------------------------
  localparam int RESULT_W = 10;
  localparam int CTRL_W = 8;
  localparam int SHORT_READ_BITS = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 100;
  localparam int TURN_NS = 100;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int TURN_CYC = (TURN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // ----------------------------------------------------------------
  // Sequencing and reset values
  // ----------------------------------------------------------------
  localparam int FALL_SKIP = 1;
  localparam int FALL_CNT_W = 4;
  localparam int HOST_CNT_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam logic SCLK_IDLE = 1'b1;
  localparam logic DATA_IDLE = 1'b1;

  typedef enum logic [2:0] {
    H_IDLE,
    H_PREP,
    H_SETUP,
    H_LOW,
    H_HIGH,
    H_END
  } host_state_t;

endpackage

/* File: verilog/serial3_if.sv */
// Purpose: Three-line link between converter port and host.
// Assumes: Each end gives data, enable (low drives) per pin.
// Notes: Undriven shared data line reads high, as a pull-up would.
`timescale 1ns/1ps
`default_nettype none

interface serial3_if;
  logic dir_sel;
  logic sclk;
  logic dev_data_o;
  logic dev_data_oe_n;
  logic host_data_o;
  logic host_data_oe_n;
  logic data_line;

  // The joined data input and output make one shared line.
  assign data_line = !dev_data_oe_n ? dev_data_o :
                     (!host_data_oe_n ? host_data_o : 1'b1);

  modport dev (
    input dir_sel,
    input sclk,
    input data_line,
    output dev_data_o,
    output dev_data_oe_n
  );

  modport host (
    output dir_sel,
    output sclk,
    output host_data_o,
    output host_data_oe_n,
    input data_line
  );
endinterface

`default_nettype wire

/* File: verilog/adc_serial_port_dev.sv */
// Purpose: Device end of the three-line converter serial port.
// Assumes: Link pins are asynchronous and are synchronised here.
// Notes: Pin reactions lag the link by about three clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Three pins: direction, shift clock, shared data.
// - Result out and control in share one pin.
// - Slave only; host always makes shift clock.
// - Host holds direction low writing, high reading.
// - Direction rise drives pin with top bit.
// - Shift on falls, first fall skipped.
// - Host samples read bits on rising edges.
// - Ten result bits, or only upper eight.
// - Host may read in bursts, direction high.
// - New read only after direction low-high.
// - Direction fall releases the data pin.
// - Capture first eight rising edges, ignore rest.
// - New write only after direction high-low.
// - Select may be grounded when bus unshared.
// - Joined data lines give three-line hookup.
// - Reading erases result until next conversion.
module adc_serial_port_dev #(
  parameter int RES_W = serial3_pkg::RESULT_W,
  parameter int CW = serial3_pkg::CTRL_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  serial3_if.dev link,
  input wire logic [RES_W-1:0] result_in,
  input wire logic result_load,
  output logic result_valid,
  output logic read_active,
  output logic [CW-1:0] ctrl_byte,
  output logic ctrl_strobe
);
  import serial3_pkg::*;

  localparam int WC_W = $clog2(CW + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Index 0 is the first stage and feeds only index 1; index 2 is the
  // previous value used to find edges.
  logic [2:0] dir_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic [1:0] din_sync_reg;

  wire dir_lvl = dir_sync_reg[1];
  wire dir_rise = dir_sync_reg[1] & ~dir_sync_reg[2];
  wire dir_fall = ~dir_sync_reg[1] & dir_sync_reg[2];
  wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire din_bit = din_sync_reg[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [RES_W-1:0] held_reg;
  logic [RES_W-1:0] shift_reg;
  logic [FALL_CNT_W-1:0] fall_cnt_reg;
  logic shifted_reg;
  logic data_o_reg;
  logic oe_n_reg;
  logic [WC_W-1:0] wr_cnt_reg;
  logic [CW-1:0] ctrl_shift_reg;

  logic [RES_W-1:0] held_next;
  logic [RES_W-1:0] shift_next;
  logic [FALL_CNT_W-1:0] fall_cnt_next;
  logic shifted_next;
  logic data_o_next;
  logic oe_n_next;
  logic valid_next;
  logic read_active_next;
  logic [WC_W-1:0] wr_cnt_next;
  logic [CW-1:0] ctrl_shift_next;
  logic [CW-1:0] ctrl_byte_next;
  logic ctrl_strobe_next;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // A conversion that lands in the same cycle as a read start is the
  // one presented, so a fresh result is never lost to a stale one.
  wire [RES_W-1:0] fresh_word = result_load ? result_in : held_reg;
  wire have_word = result_valid | result_load;
  // With no valid result the pin reads back all zeros.
  wire [RES_W-1:0] present_word = have_word ? fresh_word : '0;

  wire skip_done = fall_cnt_reg >= FALL_CNT_W'(FALL_SKIP);
  // The first fall after the direction rise only counts.
  wire shift_now = read_active & sclk_fall & skip_done;
  wire fall_cnt_max = &fall_cnt_reg;
  wire fall_count = read_active & sclk_fall & ~fall_cnt_max;

  // Erase only once a bit has actually been clocked out, so a bare
  // direction pulse used to re-arm writes keeps the result.
  wire read_erase = dir_fall & shifted_reg;

  assign held_next = result_load ? result_in : held_reg;
  // Load on a fresh direction rise only; nothing else restarts.
  assign shift_next = dir_rise ? present_word :
                      (shift_now ? {shift_reg[RES_W-2:0], 1'b0} :
                       shift_reg);
  // Remaining bits follow from the register; top bit at the rise.
  assign data_o_next = shift_next[RES_W-1];
  assign fall_cnt_next = dir_rise ? '0 :
                         (fall_count ? fall_cnt_reg + 1'b1 :
                          fall_cnt_reg);
  assign shifted_next = dir_rise ? 1'b0 : (shifted_reg | shift_now);
  // Conversion set wins over the read erase.
  assign valid_next = result_load | (result_valid & ~read_erase);

  // ----------------------------------------------------------------
  // Pin direction
  // ----------------------------------------------------------------
  // The pin turns about three clocks after the line moves, so the host
  // must leave at least that much gap before it drives the line itself.
  // The one data pin turns round with the direction line.
  assign oe_n_next = dir_rise ? 1'b0 :
                     (dir_fall ? 1'b1 : oe_n_reg);
  assign read_active_next = dir_rise ? 1'b1 :
                            (dir_fall ? 1'b0 : read_active);

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // The window only reopens after direction goes high and low.
  wire wr_open = ~dir_lvl & (wr_cnt_reg < WC_W'(CW));
  // Only the shift clock the host supplies moves data.
  wire wr_take = wr_open & sclk_rise;
  wire wr_last = wr_take & (wr_cnt_reg == WC_W'(CW - 1));
  // Top bit arrives first and ends up in the top position.
  wire [CW-1:0] ctrl_shifted = {ctrl_shift_reg[CW-2:0], din_bit};

  assign wr_cnt_next = dir_fall ? '0 :
                       (wr_take ? wr_cnt_reg + 1'b1 : wr_cnt_reg);
  assign ctrl_shift_next = wr_take ? ctrl_shifted : ctrl_shift_reg;
  assign ctrl_byte_next = wr_last ? ctrl_shifted : ctrl_byte;
  assign ctrl_strobe_next = wr_last;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Pins are only ever sampled, never driven as a clock.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_sync_reg <= '0;
      sclk_sync_reg <= {3{SCLK_IDLE}};
      din_sync_reg <= {2{DATA_IDLE}};
    end else if (ce) begin
      dir_sync_reg <= {dir_sync_reg[1:0], link.dir_sel};
      sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
      din_sync_reg <= {din_sync_reg[0], link.data_line};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      held_reg <= '0;
      shift_reg <= '0;
      fall_cnt_reg <= '0;
      shifted_reg <= 1'b0;
      data_o_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      result_valid <= 1'b0;
      read_active <= 1'b0;
    end else if (ce) begin
      held_reg <= held_next;
      shift_reg <= shift_next;
      fall_cnt_reg <= fall_cnt_next;
      shifted_reg <= shifted_next;
      data_o_reg <= data_o_next;
      oe_n_reg <= oe_n_next;
      result_valid <= valid_next;
      read_active <= read_active_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt_reg <= '0;
      ctrl_shift_reg <= '0;
      ctrl_byte <= '0;
      ctrl_strobe <= 1'b0;
    end else if (ce) begin
      wr_cnt_reg <= wr_cnt_next;
      ctrl_shift_reg <= ctrl_shift_next;
      ctrl_byte <= ctrl_byte_next;
      ctrl_strobe <= ctrl_strobe_next;
    end
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  assign link.dev_data_o = data_o_reg;
  assign link.dev_data_oe_n = oe_n_reg;

endmodule

`default_nettype wire

/* File: verilog/adc_serial_port_host.sv */
// Purpose: Host end that drives direction and shift clock.
// Assumes: Data line reaches this end asynchronously.
// Notes: Shift clock idles high and comes from a clk_sys divider.
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port_host #(
  parameter int RES_W = serial3_pkg::RESULT_W,
  parameter int CW = serial3_pkg::CTRL_W,
  parameter int HALF_CYC = serial3_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC = serial3_pkg::TURN_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  serial3_if.host link,
  input wire logic rd_req,
  input wire logic rd_short,
  input wire logic wr_req,
  input wire logic [CW-1:0] wr_byte,
  output logic busy,
  output logic [RES_W-1:0] rd_data,
  output logic rd_done,
  output logic wr_done
);
  import serial3_pkg::*;

  localparam int SB = SHORT_READ_BITS;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0] din_sync_reg;
  host_state_t state_reg, state_next;
  logic [HOST_CNT_W-1:0] cnt_reg, cnt_next;
  logic [BIT_CNT_W-1:0] bit_reg, bit_next, nbits_reg, nbits_next;
  logic is_rd_reg, is_rd_next, short_reg, short_next;
  logic [CW-1:0] tx_reg, tx_next;
  logic [RES_W-1:0] rx_reg, rx_next, rd_data_next;
  logic dir_reg, dir_next, sclk_reg, sclk_next;
  logic dout_reg, dout_next, doe_n_reg, doe_n_next;
  logic busy_next, rd_done_next, wr_done_next;

  wire din_bit = din_sync_reg[1];
  wire cnt_zero = cnt_reg == '0;
  wire [HOST_CNT_W-1:0] half_load = HOST_CNT_W'(HALF_CYC - 1);
  wire [HOST_CNT_W-1:0] gap_load = HOST_CNT_W'(GAP_CYC - 1);
  // Ten bits, or only the upper eight on request.
  wire [BIT_CNT_W-1:0] rd_bits = rd_short ? BIT_CNT_W'(SB) :
                                 BIT_CNT_W'(RES_W);
  wire [RES_W-1:0] rx_short = {rx_reg[SB-1:0], {(RES_W - SB){1'b0}}};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Each transfer first holds direction at the opposite level, so a
  // read always sees low-high and a write high-low.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
    bit_next = bit_reg;
    nbits_next = nbits_reg;
    is_rd_next = is_rd_reg;
    short_next = short_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    rd_data_next = rd_data;
    dir_next = dir_reg;
    sclk_next = sclk_reg;
    dout_next = dout_reg;
    doe_n_next = doe_n_reg;
    busy_next = busy;
    rd_done_next = 1'b0;
    wr_done_next = 1'b0;
    unique case (state_reg)
      H_IDLE: begin
        if (rd_req | wr_req) begin
          is_rd_next = rd_req;
          short_next = rd_short;
          nbits_next = rd_req ? rd_bits : BIT_CNT_W'(CW);
          tx_next = wr_byte;
          bit_next = '0;
          dir_next = ~rd_req;
          cnt_next = gap_load;
          busy_next = 1'b1;
          state_next = H_PREP;
        end
      end
      H_PREP: begin
        if (cnt_zero) begin
          dir_next = is_rd_reg;
          cnt_next = gap_load;
          state_next = H_SETUP;
        end
      end
      H_SETUP: begin
        if (cnt_zero) begin
          // The host makes every shift clock edge.
          sclk_next = 1'b0;
          cnt_next = half_load;
          doe_n_next = is_rd_reg;
          dout_next = tx_reg[CW-1];
          tx_next = {tx_reg[CW-2:0], 1'b0};
          state_next = H_LOW;
        end
      end
      H_LOW: begin
        if (cnt_zero) begin
          sclk_next = 1'b1;
          cnt_next = half_load;
          // Read bits are taken at the rising edge.
          if (is_rd_reg) begin
            rx_next = {rx_reg[RES_W-2:0], din_bit};
          end
          bit_next = bit_reg + 1'b1;
          state_next = H_HIGH;
        end
      end
      H_HIGH: begin
        if (cnt_zero) begin
          if (bit_reg == nbits_reg) begin
            cnt_next = gap_load;
            state_next = H_END;
          end else begin
            // Direction stays put across the whole read.
            sclk_next = 1'b0;
            cnt_next = half_load;
            dout_next = tx_reg[CW-1];
            tx_next = {tx_reg[CW-2:0], 1'b0};
            state_next = H_LOW;
          end
        end
      end
      H_END: begin
        if (cnt_zero) begin
          dir_next = 1'b0;
          doe_n_next = 1'b1;
          busy_next = 1'b0;
          rd_data_next = !is_rd_reg ? rd_data :
                         (short_reg ? rx_short : rx_reg);
          rd_done_next = is_rd_reg;
          wr_done_next = ~is_rd_reg;
          state_next = H_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      din_sync_reg <= {2{DATA_IDLE}};
      state_reg <= H_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      nbits_reg <= '0;
      is_rd_reg <= 1'b0;
      short_reg <= 1'b0;
      tx_reg <= '0;
      rx_reg <= '0;
    end else if (ce) begin
      din_sync_reg <= {din_sync_reg[0], link.data_line};
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      nbits_reg <= nbits_next;
      is_rd_reg <= is_rd_next;
      short_reg <= short_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= 1'b0;
      sclk_reg <= SCLK_IDLE;
      dout_reg <= DATA_IDLE;
      doe_n_reg <= 1'b1;
      busy <= 1'b0;
      rd_data <= '0;
      rd_done <= 1'b0;
      wr_done <= 1'b0;
    end else if (ce) begin
      dir_reg <= dir_next;
      sclk_reg <= sclk_next;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
      busy <= busy_next;
      rd_data <= rd_data_next;
      rd_done <= rd_done_next;
      wr_done <= wr_done_next;
    end
  end

  assign link.dir_sel = dir_reg;
  assign link.sclk = sclk_reg;
  assign link.host_data_o = dout_reg;
  assign link.host_data_oe_n = doe_n_reg;

endmodule

`default_nettype wire

/* File: test/serial3_props.sv */
// Purpose: Link checks for the three-line converter port.
// Assumes: Both link ends run on clk_sys and share one reset.
// Notes: Pin reactions may lag the link by up to five cycles.
`timescale 1ns/1ps
`default_nettype none

module serial3_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dir_sel,
  input wire logic sclk,
  input wire logic dev_data_o,
  input wire logic dev_data_oe_n,
  input wire logic host_data_o,
  input wire logic host_data_oe_n,
  input wire logic data_line
);
  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  // Falls are counted per direction window so lengths can be judged.
  logic sclk_reg;
  logic dir_reg;
  logic [4:0] falls_reg;
  logic [4:0] falls_next;
  logic [3:0] quiet_reg;
  logic [3:0] quiet_next;
  wire sclk_fell = sclk_reg && !sclk;
  assign falls_next = (dir_reg != dir_sel) ? 5'h00 :
                      falls_reg + {4'h0, sclk_fell};
  assign quiet_next = sclk_fell ? 4'h0 :
                      quiet_reg + {3'h0, quiet_reg != 4'hF};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg <= 1'b1;
      dir_reg <= 1'b0;
      falls_reg <= 5'h00;
      quiet_reg <= 4'h0;
    end else begin
      sclk_reg <= sclk;
      dir_reg <= dir_sel;
      falls_reg <= falls_next;
      quiet_reg <= quiet_next;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  no_contention_a: assert property (
    !(!dev_data_oe_n && !host_data_oe_n))
    else $error("both ends drive the data line");
  read_drive_a: assert property (
    $rose(dir_sel) |-> ##[2:5] !dev_data_oe_n)
    else $error("device did not drive on direction rise");
  release_pin_a: assert property (
    $fell(dir_sel) |-> ##[2:5] dev_data_oe_n)
    else $error("device kept the line after direction fall");
  first_fall_hold_a: assert property (dir_sel && sclk_fell &&
    falls_reg == 5'h00 |-> ##1 $stable(dev_data_o) [*5])
    else $error("device shifted on the first fall");
  shift_quiet_a: assert property (
    !dev_data_oe_n && !$past(dev_data_oe_n)
    && quiet_reg > 4'h5 |-> $stable(dev_data_o))
    else $error("device data moved without a fall");
  host_dir_write_a: assert property (!host_data_oe_n |-> !dir_sel)
    else $error("host drives data while reading");
  clk_idle_turn_a: assert property (
    $changed(dir_sel) |-> sclk && $past(sclk))
    else $error("direction moved while shift clock low");
  dir_hold_a: assert property (!sclk |-> $stable(dir_sel))
    else $error("direction moved inside a transfer");
  read_len_a: assert property ($fell(dir_sel) |->
    falls_reg inside {5'h00, 5'h08, 5'h0A})
    else $error("read length not eight or ten");
  write_len_a: assert property ($rose(dir_sel) |->
    falls_reg inside {5'h00, 5'h08})
    else $error("write length not eight");
  host_shift_a: assert property (
    $changed(host_data_o) && !host_data_oe_n |-> !sclk)
    else $error("host data moved while clock high");
  idle_pullup_a: assert property (dev_data_oe_n && host_data_oe_n
    |-> data_line)
    else $error("idle shared line not high");
endmodule

`default_nettype wire

/* File: test/adc_three_wire_serial_port_test.sv */
// Purpose: Self-checking bench for both ends of the converter port.
// Assumes: Link A joins the two design ends; link B is bench driven.
// Notes: Link B breaks the window rules on purpose to test refusals.
`timescale 1ns/1ps
`default_nettype none

module adc_three_wire_serial_port_test;
  import serial3_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [RESULT_W-1:0] result_in = 10'h000;
  logic load_a = 1'b0;
  logic load_b = 1'b0;
  logic rd_req = 1'b0;
  logic rd_short = 1'b0;
  logic wr_req = 1'b0;
  logic [CTRL_W-1:0] wr_byte = 8'h00;
  logic busy, rd_done, wr_done, result_valid, ctrl_strobe, valid_b, strobe_b;
  logic act_b;
  int wr_seen = 0;
  logic [RESULT_W-1:0] rd_data;
  logic [CTRL_W-1:0] ctrl_byte, ctrl_byte_b;
  logic [31:0] seed = 32'h00002774;
  int err_count = 0;
  int checked = 0;
  logic [RESULT_W-1:0] rq[$];
  logic [CTRL_W-1:0] cq[$], bq[$];

  serial3_if link_a();
  serial3_if link_b();

  always #(SYS_PERIOD_NS / 2) clk_sys = ~clk_sys;

  adc_serial_port_dev i_adc_serial_port_dev (.clk_sys(clk_sys),
    .rst_n(rst_n), .ce(ce), .link(link_a.dev), .result_in(result_in),
    .result_load(load_a), .result_valid(result_valid), .read_active(),
    .ctrl_byte(ctrl_byte), .ctrl_strobe(ctrl_strobe));
  adc_serial_port_dev i_adc_serial_port_dev_b (.clk_sys(clk_sys),
    .rst_n(rst_n), .ce(ce), .link(link_b.dev), .result_in(result_in),
    .result_load(load_b), .result_valid(valid_b), .read_active(act_b),
    .ctrl_byte(ctrl_byte_b), .ctrl_strobe(strobe_b));
  adc_serial_port_host i_adc_serial_port_host (.clk_sys(clk_sys),
    .rst_n(rst_n), .ce(ce), .link(link_a.host), .rd_req(rd_req),
    .rd_short(rd_short), .wr_req(wr_req), .wr_byte(wr_byte), .busy(busy),
    .rd_data(rd_data), .rd_done(rd_done), .wr_done(wr_done));
  serial3_props i_serial3_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .dir_sel(link_a.dir_sel), .sclk(link_a.sclk),
    .dev_data_o(link_a.dev_data_o), .dev_data_oe_n(link_a.dev_data_oe_n),
    .host_data_o(link_a.host_data_o),
    .host_data_oe_n(link_a.host_data_oe_n), .data_line(link_a.data_line));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      err_count = err_count + 1;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic load(input logic to_b, input logic [RESULT_W-1:0] v);
    @(negedge clk_sys);
    result_in = v;
    load_a = !to_b;
    load_b = to_b;
    @(negedge clk_sys);
    load_a = 1'b0;
    load_b = 1'b0;
  endtask

  // The extra wait lets the device's synchronisers settle after a fall.
  task automatic host_op(input logic rd, input logic sh,
                         input logic [CTRL_W-1:0] b);
    int n;
    @(negedge clk_sys);
    rd_req = rd;
    rd_short = sh;
    wr_req = !rd;
    wr_byte = b;
    @(negedge clk_sys);
    rd_req = 1'b0;
    wr_req = 1'b0;
    chk(busy, 1'b1);
    for (n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge clk_sys);
    chk(busy, 1'b0);
    repeat (8) @(negedge clk_sys);
  endtask

  // Shift clock for link B; it idles high between frames.
  task automatic b_clk(input int n, input logic [CTRL_W-1:0] d,
                       inout logic [RESULT_W-1:0] q);
    for (int i = 0; i < n; i++) begin
      link_b.sclk = 1'b0;
      link_b.host_data_o = d[CTRL_W-1];
      d = {d[CTRL_W-2:0], ~d[0]};
      #62.5;
      link_b.sclk = 1'b1;
      q = {q[RESULT_W-2:0], link_b.data_line};
      #62.5;
    end
  endtask

  // ------------------------------------------------------------
  // Monitor and sequence
  // ------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (rd_done === 1'b1) begin
      chk(rd_data, rq.size() ? rq.pop_front() : 10'hXXX);
    end
    if (ctrl_strobe === 1'b1) begin
      chk(ctrl_byte, cq.size() ? cq.pop_front() : 8'hXX);
    end
    if (strobe_b === 1'b1) begin
      chk(ctrl_byte_b, bq.size() ? bq.pop_front() : 8'hXX);
    end
    if (wr_done === 1'b1) begin
      wr_seen = wr_seen + 1;
      chk(16'(cq.size()), 16'h0000);
    end
  end

  initial begin
    logic [RESULT_W-1:0] v;
    logic [RESULT_W-1:0] q;
    logic [CTRL_W-1:0] b;
    link_b.dir_sel = 1'b0;
    link_b.sclk = 1'b1;
    link_b.host_data_o = 1'b1;
    link_b.host_data_oe_n = 1'b1;
    q = 10'h000;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int k = 0; k < 3; k++) begin
      v = RESULT_W'(rnd());
      load(1'b0, v);
      chk(result_valid, 1'b1);
      rq.push_back(k == 1 ? {v[9:2], 2'b00} : v);
      host_op(1'b1, k == 1, 8'h00);
      chk(result_valid, 1'b0);
      b = CTRL_W'(rnd());
      cq.push_back(b);
      host_op(1'b0, 1'b0, b);
    end
    rq.push_back(10'h000);
    host_op(1'b1, 1'b0, 8'h00);
    b = CTRL_W'(rnd());
    v = RESULT_W'(rnd());
    ce = 1'b0;
    load(1'b1, ~v);
    ce = 1'b1;
    chk(valid_b, 1'b0);
    load(1'b1, v);
    #3;
    link_b.host_data_oe_n = 1'b0;
    bq.push_back(b);
    b_clk(12, b, q);
    #500;
    b_clk(8, ~b, q);
    #500;
    link_b.host_data_oe_n = 1'b1;
    link_b.dir_sel = 1'b1;
    #200;
    chk(link_b.data_line, v[9]);
    chk(act_b, 1'b1);
    b_clk(10, 8'h00, q);
    chk(q, v);
    b_clk(2, 8'h00, q);
    chk(q[1:0], 2'b00);
    link_b.dir_sel = 1'b0;
    #200;
    chk(link_b.data_line, 1'b1);
    chk(act_b, 1'b0);
    chk(valid_b, 1'b0);
    link_b.host_data_oe_n = 1'b0;
    bq.push_back(~b);
    b_clk(8, ~b, q);
    #500;
    chk(16'(rq.size() + cq.size() + bq.size()), 16'h0000);
    chk(16'(wr_seen), 16'h0003);
    report_and_stop();
  end

  // The whole sequence needs under 40 us; 100 us means a hang.
  initial begin
    #100000;
    err_count = err_count + 1;
    report_and_stop();
  end
endmodule

`default_nettype wire
